// ===== ubm_break_top.sv
// Break-condition matching unit: register file on Avalon-MM and the break request generator.
// Assumes the watched bus attributes and Avalon signals are synchronous to mclk.
module ubm_break_top
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Avalon-MM register slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Observed bus cycle
   input wire logic busCycleValid,
   input wire logic [31:0] busCycleAddr,
   input wire logic busCycleDma,
   input wire logic busCycleFetch,
   input wire logic busCycleWrite,
   input wire logic [1:0] busCycleSize,
   // Break request to the interrupt controller
   output logic userBreakReq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   // Break condition registers and their next values
   logic [15:0] breakAddrUpper_ff;
   logic [15:0] breakAddrLower_ff;
   logic [15:0] addrMaskUpper_ff;
   logic [15:0] addrMaskLower_ff;
   logic [7:0] cycleCond_ff;
   logic [15:0] nxt_breakAddrUpper;
   logic [15:0] nxt_breakAddrLower;
   logic [15:0] nxt_addrMaskUpper;
   logic [15:0] nxt_addrMaskLower;
   logic [7:0] nxt_cycleCond;

   // Register bus answer
   logic waitReq_ff;
   logic nxt_waitReq;
   logic [31:0] readData_ff;
   logic [31:0] nxt_readData;

   // Break request and hit counter
   logic breakReq_ff;
   logic nxt_breakReq;
   logic [15:0] breakCount_ff;
   logic [15:0] nxt_breakCount;

   // Decode and match helpers
   logic busReq;
   logic commitWrite;
   logic [15:0] wrData16;
   logic [15:0] wrMask16;
   logic [31:0] fullBreakAddr;
   logic [31:0] fullAddrMask;
   logic addrMatch;
   logic cycleMatch;

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   // One wait state on every access: the request is seen with waitrequest high,
   // read data are captured, and the next edge completes it. Writes land only
   // at the completing edge so a held request is never written twice.

   assign busReq = avs_read | avs_write;
   assign commitWrite = avs_write & ~waitReq_ff;

   always_comb
   begin
      nxt_waitReq = ~(busReq & waitReq_ff);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         waitReq_ff <= 1'b1;
      end
      else
      begin
         waitReq_ff <= nxt_waitReq;
      end
   end

   assign avs_waitrequest = waitReq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Byte lane merge for the 16-bit registers; lanes 2 and 3 hit nothing

   assign wrMask16 = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wrData16 = avs_writedata[15:0];

   ////////////////////////////////////////////////////////////////////////////
   // Break condition registers
   // No standby input reaches these flops: only rst_b clears them.

   always_comb
   begin
      nxt_breakAddrUpper = breakAddrUpper_ff;
      nxt_breakAddrLower = breakAddrLower_ff;
      nxt_addrMaskUpper = addrMaskUpper_ff;
      nxt_addrMaskLower = addrMaskLower_ff;
      nxt_cycleCond = cycleCond_ff;
      if (commitWrite)
      begin
         unique case (avs_address)
            ubm_pkg::OFS_BREAK_ADDR_UPPER:
            begin
               nxt_breakAddrUpper = (breakAddrUpper_ff & ~wrMask16) | (wrData16 & wrMask16);
            end
            ubm_pkg::OFS_BREAK_ADDR_LOWER:
            begin
               nxt_breakAddrLower = (breakAddrLower_ff & ~wrMask16) | (wrData16 & wrMask16);
            end
            ubm_pkg::OFS_ADDR_MASK_UPPER:
            begin
               nxt_addrMaskUpper = (addrMaskUpper_ff & ~wrMask16) | (wrData16 & wrMask16);
            end
            ubm_pkg::OFS_ADDR_MASK_LOWER:
            begin
               nxt_addrMaskLower = (addrMaskLower_ff & ~wrMask16) | (wrData16 & wrMask16);
            end
            ubm_pkg::OFS_CYCLE_CONDITION:
            begin
               // Reserved upper byte is not stored at all
               if (avs_byteenable[0])
               begin
                  nxt_cycleCond = avs_writedata[7:0];
               end
            end
            ubm_pkg::OFS_BREAK_COUNT:
            begin
               // Read-only hit counter: software cannot preset it
            end
            default:
            begin
               // Unmapped offset: write is dropped
               nxt_cycleCond = cycleCond_ff;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         breakAddrUpper_ff <= ubm_pkg::RST_BREAK_ADDR;
         breakAddrLower_ff <= ubm_pkg::RST_BREAK_ADDR;
         addrMaskUpper_ff <= ubm_pkg::RST_ADDR_MASK;
         addrMaskLower_ff <= ubm_pkg::RST_ADDR_MASK;
         cycleCond_ff <= ubm_pkg::RST_CYCLE_CONDITION;
      end
      else
      begin
         // Held across standby; nothing but reset clears them
         breakAddrUpper_ff <= nxt_breakAddrUpper;
         breakAddrLower_ff <= nxt_breakAddrLower;
         addrMaskUpper_ff <= nxt_addrMaskUpper;
         addrMaskLower_ff <= nxt_addrMaskLower;
         cycleCond_ff <= nxt_cycleCond;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, captured at the edge that first sees the request

   always_comb
   begin
      nxt_readData = readData_ff;
      if (avs_read & waitReq_ff)
      begin
         unique case (avs_address)
            ubm_pkg::OFS_BREAK_ADDR_UPPER:
            begin
               nxt_readData = {16'h0000, breakAddrUpper_ff};
            end
            ubm_pkg::OFS_BREAK_ADDR_LOWER:
            begin
               nxt_readData = {16'h0000, breakAddrLower_ff};
            end
            ubm_pkg::OFS_ADDR_MASK_UPPER:
            begin
               nxt_readData = {16'h0000, addrMaskUpper_ff};
            end
            ubm_pkg::OFS_ADDR_MASK_LOWER:
            begin
               nxt_readData = {16'h0000, addrMaskLower_ff};
            end
            ubm_pkg::OFS_CYCLE_CONDITION:
            begin
               nxt_readData = {24'h000000, cycleCond_ff};
            end
            ubm_pkg::OFS_BREAK_COUNT:
            begin
               nxt_readData = {16'h0000, breakCount_ff};
            end
            default:
            begin
               nxt_readData = 32'h00000000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         readData_ff <= 32'h00000000;
      end
      else
      begin
         readData_ff <= nxt_readData;
      end
   end

   assign avs_readdata = readData_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Matching
   // Conditions are taken as they stand in the cycle the bus cycle is seen, so
   // a rewrite lands on the next observed cycle, not the one in flight.
   // Fetch breaks with the size field at byte or longword never fire, since every
   // fetch compares as a word; keeping the low size bit clear is up to software.

   assign fullBreakAddr = {breakAddrUpper_ff, breakAddrLower_ff};
   assign fullAddrMask = {addrMaskUpper_ff, addrMaskLower_ff};

   ubm_addr_compare u_addr_compare
   (
      .breakAddr(fullBreakAddr),
      .addrMask(fullAddrMask),
      .cycleAddr(busCycleAddr),
      .addrMatch(addrMatch)
   );

   ubm_cycle_qualify u_cycle_qualify
   (
      .cond(cycleCond_ff),
      .cycleDma(busCycleDma),
      .cycleFetch(busCycleFetch),
      .cycleWrite(busCycleWrite),
      .cycleSize(busCycleSize),
      .cycleMatch(cycleMatch)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Break request and break counter
   // The request is a one-cycle pulse per matching cycle; holding it pending is
   // the interrupt controller's job. The counter saturates rather than wrap so
   // a debugger never mistakes many hits for none.

   always_comb
   begin
      nxt_breakReq = busCycleValid & addrMatch & cycleMatch;
      nxt_breakCount = breakCount_ff;
      if (breakReq_ff && (breakCount_ff != ubm_pkg::BREAK_COUNT_MAX))
      begin
         nxt_breakCount = breakCount_ff + 16'h0001;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         breakReq_ff <= 1'b0;
         breakCount_ff <= ubm_pkg::RST_BREAK_COUNT;
      end
      else
      begin
         breakReq_ff <= nxt_breakReq;
         breakCount_ff <= nxt_breakCount;
      end
   end

   assign userBreakReq = breakReq_ff;

endmodule : ubm_break_top

// ===== ubm_pkg.sv
// Constants shared by the break-condition matching block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and 32-bit bus cycles being watched.
package ubm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Widths
   localparam int REG_W = 16;
   localparam int COND_W = 8;
   localparam int BUS_ADDR_W = 32;
   localparam int AVS_ADDR_W = 8;
   localparam int AVS_DATA_W = 32;
   localparam int AVS_BE_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_BREAK_ADDR_UPPER = 8'h00;
   localparam logic [7:0] OFS_BREAK_ADDR_LOWER = 8'h04;
   localparam logic [7:0] OFS_ADDR_MASK_UPPER = 8'h08;
   localparam logic [7:0] OFS_ADDR_MASK_LOWER = 8'h0c;
   localparam logic [7:0] OFS_CYCLE_CONDITION = 8'h10;
   localparam logic [7:0] OFS_BREAK_COUNT = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [15:0] RST_BREAK_ADDR = 16'h0000;
   localparam logic [15:0] RST_ADDR_MASK = 16'h0000;
   localparam logic [7:0] RST_CYCLE_CONDITION = 8'h00;
   localparam logic [15:0] RST_BREAK_COUNT = 16'h0000;
   localparam logic [15:0] BREAK_COUNT_MAX = 16'hffff;

   ////////////////////////////////////////////////////////////////////////////
   // Cycle condition field positions (low bit of each two-bit field)
   localparam int FLD_MASTER_LO = 6;
   localparam int FLD_ACCESS_LO = 4;
   localparam int FLD_DIRECTION_LO = 2;
   localparam int FLD_SIZE_LO = 0;

   ////////////////////////////////////////////////////////////////////////////
   // Two-bit select encodings
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_FIRST = 2'h1;
   localparam logic [1:0] SEL_SECOND = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // Operand sizes, shared by the watched bus and the size field
   localparam logic [1:0] SIZE_ANY = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_LONG = 2'h3;

endpackage : ubm_pkg

// ===== ubm_addr_compare.sv
// Masked comparison of a bus address against the stored break address.
// Assumes all inputs come from flops or ports on the same clock; output is combinational.
module ubm_addr_compare
(
   // Stored break condition
   input wire logic [31:0] breakAddr,
   input wire logic [31:0] addrMask,
   // Observed cycle
   input wire logic [31:0] cycleAddr,
   // Result
   output logic addrMatch
);

   logic [31:0] bitOk;

   ////////////////////////////////////////////////////////////////////////////
   // A set mask bit turns its address bit into a don't care
   for (genvar i = 0; i < 32; i++)
   begin : g_bit
      assign bitOk[i] = addrMask[i] | (cycleAddr[i] == breakAddr[i]);
   end

   assign addrMatch = &bitOk;

endmodule : ubm_addr_compare

// ===== ubm_cycle_qualify.sv
// Decode of the bus cycle condition fields against one observed bus cycle.
// Assumes the cycle attributes are stable for the cycle they describe; output is combinational.
module ubm_cycle_qualify
(
   // Programmed condition
   input wire logic [7:0] cond,
   // Observed cycle attributes
   input wire logic cycleDma,
   input wire logic cycleFetch,
   input wire logic cycleWrite,
   input wire logic [1:0] cycleSize,
   // Result
   output logic cycleMatch
);

   logic [1:0] masterSel;
   logic [1:0] accessSel;
   logic [1:0] dirSel;
   logic [1:0] sizeSel;
   logic [1:0] effSize;
   logic masterOk;
   logic accessOk;
   logic dirOk;
   logic sizeOk;

   assign masterSel = cond[ubm_pkg::FLD_MASTER_LO +: 2];
   assign accessSel = cond[ubm_pkg::FLD_ACCESS_LO +: 2];
   assign dirSel = cond[ubm_pkg::FLD_DIRECTION_LO +: 2];
   assign sizeSel = cond[ubm_pkg::FLD_SIZE_LO +: 2];

   // Fetches count as words whatever the path width; data uses its own operand size
   assign effSize = cycleFetch ? ubm_pkg::SIZE_WORD : cycleSize;

   // Bit 0 of the master, access and direction selects enables the first kind, bit 1 the second; 00 there never matches
   assign masterOk = cycleDma ? masterSel[1] : masterSel[0];
   assign accessOk = cycleFetch ? accessSel[0] : accessSel[1];
   assign dirOk = cycleWrite ? dirSel[1] : dirSel[0];
   assign sizeOk = (sizeSel == ubm_pkg::SIZE_ANY) || (sizeSel == effSize);

   assign cycleMatch = masterOk & accessOk & dirOk & sizeOk;

endmodule : ubm_cycle_qualify

// ===== ubm_break_chk.sv
// Port checks for ubm_break_top, with shadow copies of the registers.
// Assumes it is bound to ubm_break_top and sees only its ports.
module ubm_break_chk
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Register bus
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Watched cycle and request
   input wire logic busCycleValid,
   input wire logic [31:0] busCycleAddr,
   input wire logic busCycleDma,
   input wire logic busCycleFetch,
   input wire logic busCycleWrite,
   input wire logic [1:0] busCycleSize,
   input wire logic userBreakReq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   logic [15:0] sh_ff [5];
   logic [15:0] nxt_sh [5];
   logic [7:0] c;
   logic addrOk, mstOk, accOk, dirOk, sizeOk, fieldsOn, hit;
   always_comb
   begin
      nxt_sh = sh_ff;
      if (avs_write && !avs_waitrequest && avs_address[1:0] == 2'h0 && avs_address < 8'h14)
      begin
         if (avs_byteenable[0])
            nxt_sh[avs_address[4:2]][7:0] = avs_writedata[7:0];
         if (avs_byteenable[1] && avs_address < 8'h10)
            nxt_sh[avs_address[4:2]][15:8] = avs_writedata[15:8];
      end
      if (!rst_b)
         nxt_sh = '{default: 16'h0000};
   end
   always_ff @(posedge mclk)
      sh_ff <= nxt_sh;
   assign c = sh_ff[4][7:0];
   assign addrOk = ((busCycleAddr ^ {sh_ff[0], sh_ff[1]}) & ~{sh_ff[2], sh_ff[3]}) == 32'h0;
   assign mstOk = busCycleDma ? c[7] : c[6];
   assign accOk = busCycleFetch ? c[4] : c[5];
   assign dirOk = busCycleWrite ? c[3] : c[2];
   // Fetches always compare as word accesses
   assign sizeOk = c[1:0] == 2'h0 || c[1:0] == (busCycleFetch ? 2'h2 : busCycleSize);
   assign fieldsOn = (|c[7:6]) && (|c[5:4]) && (|c[3:2]);
   assign hit = busCycleValid && addrOk && mstOk && accOk && dirOk && sizeOk && fieldsOn;
   ////////////////////////////////////////////////////////////////////////////
   property p_fire; hit |=> userBreakReq; endproperty
   a_fire: assert property (p_fire)
      else $error("no break after matching cycle");
   property p_addr; userBreakReq |-> $past(busCycleValid) && $past(addrOk); endproperty
   a_addr: assert property (p_addr)
      else $error("break on unmatched address");
   property p_mst; userBreakReq |-> $past(mstOk); endproperty
   a_mst: assert property (p_mst)
      else $error("break on wrong master");
   property p_acc; userBreakReq |-> $past(accOk); endproperty
   a_acc: assert property (p_acc)
      else $error("break on wrong access type");
   property p_dir; userBreakReq |-> $past(dirOk); endproperty
   a_dir: assert property (p_dir)
      else $error("break on wrong direction");
   property p_size; userBreakReq |-> $past(sizeOk); endproperty
   a_size: assert property (p_size)
      else $error("break on wrong size");
   property p_fields; userBreakReq |-> $past(fieldsOn); endproperty
   a_fields: assert property (p_fields)
      else $error("break with a field at 00");
   property p_upper;
      avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0 && (avs_address != 8'h10 || avs_readdata[15:8] == 8'h0);
   endproperty
   a_upper: assert property (p_upper)
      else $error("reserved read bits not zero");
   property p_back;
      avs_read && !avs_waitrequest && avs_address[1:0] == 2'h0 && avs_address < 8'h14 |-> avs_readdata[15:0] == sh_ff[avs_address[4:2]];
   endproperty
   a_back: assert property (p_back)
      else $error("register readback differs");
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
   a_wait: assert property (p_wait)
      else $error("bus answer not one wait cycle");
   cover property (hit);
   cover property (userBreakReq [*2]);
   cover property (avs_read && !avs_waitrequest);
endmodule : ubm_break_chk

bind ubm_break_top ubm_break_chk u_chk (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .busCycleValid(busCycleValid), .busCycleAddr(busCycleAddr),
   .busCycleDma(busCycleDma), .busCycleFetch(busCycleFetch), .busCycleWrite(busCycleWrite),
   .busCycleSize(busCycleSize), .userBreakReq(userBreakReq));

// ===== ubm_bus_model.sv
// Far side: CPU or DMA bus cycles and the interrupt controller's request count.
// Assumes the bench raises go for one clock per cycle with {dma, fetch, write, size, addr} on cyc.
module ubm_bus_model
(
   // Bench request
   input wire logic mclk,
   input wire logic go,
   input wire logic [36:0] cyc,
   // Watched bus
   output logic busCycleValid = 1'b0,
   output logic [31:0] busCycleAddr = 32'h0,
   output logic busCycleDma = 1'b0,
   output logic busCycleFetch = 1'b0,
   output logic busCycleWrite = 1'b0,
   output logic [1:0] busCycleSize = 2'h0,
   // Interrupt controller
   input wire logic userBreakReq,
   output int breakCnt = 0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle cycles flip every attribute so a design that ignores valid is caught;
   // an unknown request counts as a break so it cannot hide in the count
   always @(posedge mclk)
   begin
      busCycleValid <= go;
      {busCycleDma, busCycleFetch, busCycleWrite, busCycleSize} <= go ? cyc[36:32] : ~cyc[36:32];
      busCycleAddr <= go ? cyc[31:0] : ~busCycleAddr;
      if (userBreakReq !== 1'b0)
         breakCnt <= breakCnt + 1;
   end
endmodule : ubm_bus_model

// ===== tb_ubm_break_top.sv
// Self-checking bench for ubm_break_top: row table of break conditions, then hand-written cases.
// Assumes ubm_bus_model plays the watched bus and the interrupt controller.
module tb_ubm_break_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [45:0] ubm_row_type; // {cond, dma fetch write size, address flip, expected}
   localparam logic [31:0] BRK = 32'h0076bcdc;
   localparam ubm_row_type ROWS [15] = '{
      {8'ha7, 5'h13, 32'h0, 1'b1}, {8'ha7, 5'h03, 32'h0, 1'b0}, {8'h6a, 5'h06, 32'h0, 1'b1},
      {8'h6a, 5'h02, 32'h0, 1'b0}, {8'h6a, 5'h05, 32'h0, 1'b0},
      {8'h54, 5'h09, 32'h0, 1'b1}, {8'h56, 5'h09, 32'h0, 1'b1},
      {8'h14, 5'h08, 32'h0, 1'b0}, {8'h44, 5'h02, 32'h0, 1'b0}, {8'h60, 5'h02, 32'h0, 1'b0},
      {8'hfc, 5'h17, 32'h0, 1'b1}, {8'h65, 5'h01, 32'h0, 1'b1}, {8'h66, 5'h0a, 32'h0, 1'b0},
      {8'h6a, 5'h06, 32'h1, 1'b0}, {8'hfc, 5'h17, 32'h80000000, 1'b0}};
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic go = 1'b0;
   logic [36:0] cyc = 37'h0;
   logic [31:0] avs_readdata, busCycleAddr, q;
   logic avs_waitrequest, userBreakReq, busCycleValid, busCycleDma, busCycleFetch, busCycleWrite;
   logic [1:0] busCycleSize;
   int breakCnt, base, total = 0, err_count = 0, cmp_count = 0;
   always #25 mclk = ~mclk;
   ubm_break_top u_dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busCycleValid(busCycleValid),
      .busCycleAddr(busCycleAddr), .busCycleDma(busCycleDma), .busCycleFetch(busCycleFetch),
      .busCycleWrite(busCycleWrite), .busCycleSize(busCycleSize), .userBreakReq(userBreakReq));
   ubm_bus_model u_bus (.mclk(mclk), .go(go), .cyc(cyc), .busCycleValid(busCycleValid), .busCycleAddr(busCycleAddr),
      .busCycleDma(busCycleDma), .busCycleFetch(busCycleFetch), .busCycleWrite(busCycleWrite),
      .busCycleSize(busCycleSize), .userBreakReq(userBreakReq), .breakCnt(breakCnt));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t reg got=%h exp=%h", $time, got, exp);
      end
   endtask : chkReg
   task automatic chkCnt(input int got, input int exp);
      cmp_count++;
      if (got != exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t breaks got=%h exp=%h", $time, got, exp);
      end
   endtask : chkCnt
   // One bus access, held until waitrequest is sampled low; one idle edge after release
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] rd);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      // Only the watchdog ends a wait that never gets an answer
      do
         @(posedge mclk);
      while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge mclk);
   endtask : acc
   task automatic sendCyc(input logic [4:0] at, input logic [31:0] adr);
      go <= 1'b1;
      cyc <= {at, adr};
      @(posedge mclk);
      go <= 1'b0;
      repeat (3) @(posedge mclk);
   endtask : sendCyc
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (5000) @(posedge mclk);
      err_count++;
      summarize();
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 7; i++)
      begin
         acc(1'b0, 8'(i * 4), 32'h0, 4'h0, q);
         chkReg(q, 32'h0);
      end
      acc(1'b1, 8'h00, {16'h0, BRK[31:16]}, 4'h3, q);
      acc(1'b1, 8'h04, {16'h0, BRK[15:0]}, 4'h3, q);
      foreach (ROWS[i])
      begin
         acc(1'b1, 8'h10, {24'h0, ROWS[i][45:38]}, 4'h1, q);
         base = breakCnt;
         total += int'(ROWS[i][0]);
         sendCyc(ROWS[i][37:33], BRK ^ ROWS[i][32:1]);
         chkCnt(breakCnt - base, int'(ROWS[i][0]));
      end
      // Bits 31 and 0 masked; bit 16 still compares
      acc(1'b1, 8'h08, 32'h8000, 4'h3, q);
      acc(1'b1, 8'h0c, 32'h0001, 4'h3, q);
      base = breakCnt;
      sendCyc(5'h17, BRK ^ 32'h80000001);
      sendCyc(5'h17, BRK ^ 32'h00010000);
      chkCnt(breakCnt - base, 1);
      go <= 1'b1;
      cyc <= {5'h17, BRK};
      repeat (2) @(posedge mclk);
      go <= 1'b0;
      repeat (3) @(posedge mclk);
      chkCnt(breakCnt - base, 3);
      total += 3;
      acc(1'b1, 8'h00, 32'hffffaa00, 4'h2, q);
      acc(1'b0, 8'h00, 32'h0, 4'h0, q);
      chkReg(q, 32'h0000aa76);
      acc(1'b0, 8'h08, 32'h0, 4'h0, q);
      chkReg(q, 32'h00008000);
      acc(1'b0, 8'h10, 32'h0, 4'h0, q);
      chkReg(q, 32'h000000fc);
      acc(1'b1, 8'h14, 32'h1234, 4'h3, q);
      acc(1'b0, 8'h14, 32'h0, 4'h0, q);
      chkReg(q, 32'(total));
      // Reset in mid-run clears masks and condition
      rst_b <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      acc(1'b0, 8'h0c, 32'h0, 4'h0, q);
      chkReg(q, 32'h0);
      acc(1'b0, 8'h10, 32'h0, 4'h0, q);
      chkReg(q, 32'h0);
      base = breakCnt;
      sendCyc(5'h17, 32'h0);
      chkCnt(breakCnt - base, 0);
      summarize();
   end
endmodule : tb_ubm_break_top
